/* sim/status_ctrl_props.sv */
// Concurrent checks on the status LED and start-up switch block
`default_nettype none
module status_ctrl_props (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic SWITCH_2_N,
  input wire logic DSR_N,
  input wire logic [1:0] DSR_FUNC,
  input wire logic LINK_CONNECTING,
  input wire logic LINK_CONNECTED,
  input wire logic DATA_ACTIVITY,
  input wire logic RED_N,
  input wire logic GREEN_N,
  input wire logic BLUE_N,
  input wire logic SERIAL_DEFAULTS,
  input wire logic FACTORY_DEFAULTS,
  input wire logic BOOTLOADER,
  input wire logic CONNECT_REQ,
  input wire logic DISCONNECT_REQ,
  input wire logic UART_ENABLE
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [2:0] rgb = {RED_N, GREEN_N, BLUE_N};
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  a_led_legal: assert property (rgb inside {3'h7, 3'h5, 3'h1, 3'h2, 3'h6})
    else $error("LED shows undefined colour");
  a_idle_colour: assert property (rgb inside {3'h5, 3'h1} |-> $past(!LINK_CONNECTING && !LINK_CONNECTED, 2))
    else $error("idle colour while link busy");
  a_purple_cause: assert property (rgb == 3'h2 |-> $past(LINK_CONNECTING && !LINK_CONNECTED, 2))
    else $error("purple without connecting link");
  a_blue_cause: assert property (rgb == 3'h6 |-> $past(LINK_CONNECTED, 2))
    else $error("blue without connected link");
  a_flash_dark: assert property (rgb == 3'h6 && LINK_CONNECTED && DATA_ACTIVITY |-> ##[1:4] rgb == 3'h7)
    else $error("no flash on activity");
  a_serial_hold: assert property (SERIAL_DEFAULTS |=> SERIAL_DEFAULTS)
    else $error("serial defaults flag dropped");
  a_connect_pulse: assert property (CONNECT_REQ |-> (!$past(SWITCH_2_N) || !$past(SWITCH_2_N, 2)) ##1 !CONNECT_REQ)
    else $error("connect request without press or too long");
  a_factory_exit: assert property (FACTORY_DEFAULTS |-> !BOOTLOADER ##1 FACTORY_DEFAULTS)
    else $error("factory defaults with bootloader or dropped");
  a_disc_pulse: assert property (DISCONNECT_REQ |-> $past(DSR_FUNC) == 2'h1 ##1 !DISCONNECT_REQ)
    else $error("bad disconnect request");
  a_uart_gate: assert property ($past(RST_N, 3) && $past(DSR_FUNC) == 2'h2 |-> UART_ENABLE == !$past(DSR_N))
    else $error("serial enable not following input");
  c_blue: cover property (rgb == 3'h6);
  c_factory: cover property ($rose(FACTORY_DEFAULTS));
  c_connect: cover property (CONNECT_REQ);
endmodule
`default_nettype wire

/* sim/switch_led_model.sv */
// Push-button and RGB LED model on the far side of the block
`default_nettype none
module switch_led_model (
  input wire logic MCLK,
  input wire logic [1:0] press,
  input wire logic RED_N,
  input wire logic GREEN_N,
  input wire logic BLUE_N,
  output logic SWITCH_1_N,
  output logic SWITCH_2_N,
  output logic [2:0] lit
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(negedge MCLK) begin
    SWITCH_1_N <= !press[0];
    SWITCH_2_N <= !press[1];
  end
  assign lit = ~{RED_N, GREEN_N, BLUE_N};
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the status LED and start-up switch block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20;
  typedef struct {int sel; logic [2:0] exp;} note_s;
  logic MCLK, RST_N, SWITCH_1_N, SWITCH_2_N, DSR_N, EXT_FRAMED_SEL, LINK_CONNECTING, LINK_CONNECTED;
  logic LINK_BONDED, LINK_PROFILE, DATA_ACTIVITY, CMD_MODE_EXIT, RED_N, GREEN_N, BLUE_N, DTR_N;
  logic SERIAL_DEFAULTS, FACTORY_DEFAULTS, BOOTLOADER, CONNECT_REQ, DISCONNECT_REQ, CONNECTABLE;
  logic UART_ENABLE, SLEEP;
  logic [1:0] DSR_FUNC, DTR_FUNC, press;
  logic [2:0] lit, r, c0;
  logic [2:0] cr = 3'h0;
  logic [2:0] dr = 3'h0;
  int mismatches, comparisons;
  note_s notes[$];
  status_led_and_startup_switch_ctrl #(.HOLD_CYCLES(HOLD)) DUT (.*);
  switch_led_model far (.*);
  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end
  always @(posedge MCLK) begin
    cr <= cr + 3'(CONNECT_REQ);
    dr <= dr + 3'(DISCONNECT_REQ);
  end
  // ----------------------------------------
  // Scoreboard
  // ----------------------------------------
  function automatic logic [2:0] pick(int sel);
    case (sel)
      0: return ~lit;
      1: return {SERIAL_DEFAULTS, BOOTLOADER, FACTORY_DEFAULTS};
      2: return {CONNECTABLE, UART_ENABLE, SLEEP};
      3: return {2'h0, DTR_N};
      4: return cr;
      5: return dr;
      default: return {2'h0, SLEEP};
    endcase
  endfunction
  task check(input logic [2:0] seen, input logic [2:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  initial forever begin
    note_s n;
    wait (notes.size() > 0);
    n = notes.pop_front();
    check(pick(n.sel), n.exp);
  end
  task note(input int sel, input logic [2:0] exp);
    notes.push_back('{sel, exp});
  endtask
  task cyc(input int n);
    repeat (n) @(negedge MCLK);
  endtask
  task go(input logic [1:0] pr);
    press = pr;
    RST_N = 1'b0;
    cyc(10);
    note(0, 3'h7);
    note(2, 3'h6);
    RST_N = 1'b1;
    cyc(1);
    note(0, 3'h7);
    cyc(4);
  endtask
  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge MCLK);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {RST_N, DSR_FUNC, DTR_FUNC, EXT_FRAMED_SEL, LINK_CONNECTING, LINK_CONNECTED} = '0;
    {LINK_BONDED, LINK_PROFILE, DATA_ACTIVITY, CMD_MODE_EXIT, press} = '0;
    DSR_N = 1'b1;
    void'($urandom(32'hFDCA));
    for (int i = 0; i < 5; i++) begin
      go(i == 4 ? 2'h3 : 2'(i));
      note(1, {i[1] || i == 4, i >= 3, 1'b0});
      if (i >= 3) begin
        if (i == 4) press = 2'h0;
        cyc(HOLD + 5);
        note(1, i == 3 ? 3'h5 : 3'h6);
      end
      press = 2'h0;
    end
    $display("start-up switches done");
    go(2'h0);
    note(0, 3'h5);
    EXT_FRAMED_SEL = 1'b1;
    cyc(3);
    note(0, 3'h5);
    DSR_N = 1'b0;
    cyc(4);
    note(0, 3'h1);
    note(3, 3'h1);
    DSR_N = 1'b1;
    LINK_CONNECTING = 1'b1;
    cyc(4);
    note(0, 3'h2);
    LINK_CONNECTED = 1'b1;
    cyc(4);
    note(0, 3'h6);
    DATA_ACTIVITY = 1'b1;
    cyc(1);
    DATA_ACTIVITY = 1'b0;
    cyc(3);
    note(0, 3'h7);
    {LINK_CONNECTING, LINK_CONNECTED, CMD_MODE_EXIT} = 3'h1;
    cyc(1);
    CMD_MODE_EXIT = 1'b0;
    cyc(4);
    note(0, 3'h5);
    note(3, 3'h0);
    $display("status colours done");
    go(2'h0);
    c0 = cr;
    press = 2'h2;
    cyc(5);
    press = 2'h0;
    cyc(3);
    note(4, c0 + 3'h1);
    DSR_FUNC = 2'h1;
    c0 = dr;
    cyc(2);
    DSR_N = 1'b0;
    cyc(4);
    note(5, c0 + 3'h1);
    DSR_N = 1'b1;
    cyc(2);
    note(2, 3'h2);
    DSR_FUNC = 2'h2;
    DSR_N = 1'b0;
    cyc(3);
    note(2, 3'h2);
    DSR_N = 1'b1;
    cyc(3);
    note(2, 3'h0);
    DSR_FUNC = 2'h3;
    DSR_N = 1'b0;
    cyc(3);
    DSR_N = 1'b1;
    cyc(3);
    note(6, 3'h1);
    DSR_N = 1'b0;
    cyc(3);
    note(6, 3'h0);
    $display("switch and serial control done");
    for (int j = 0; j < 6; j++) begin
      r = 3'($urandom);
      DTR_FUNC = 2'(1 + j % 3);
      {LINK_PROFILE, LINK_BONDED, LINK_CONNECTED} = r;
      cyc(5);
      note(3, {2'h0, !r[j % 3]});
    end
    $display("status report done");
    wait (notes.size() == 0);
    cyc(1);
    tally_and_finish();
  end
endmodule
bind status_led_and_startup_switch_ctrl status_ctrl_props u_props (.*);
`default_nettype wire

/* src/edge_detect.sv */
// Falling- and rising-edge detector for a synchronous low-active input
`default_nettype none
module edge_detect (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic fall,
  output logic rise
);
  logic prev;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev <= 1'b1;
    end else begin
      prev <= din;
    end
  end

  assign fall = prev && !din;
  assign rise = !prev && din;
endmodule
`default_nettype wire

/* src/led_encoder.sv */
// Maps mode and link status onto active-low RGB drive levels
`default_nettype none
module led_encoder (
  input wire logic clk,
  input wire logic rst_n,
  status_if.dst st,
  output logic [2:0] rgb
);
  logic [23:0] flash_cnt;

  // ----------------------------------------
  // Activity flash timer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flash_cnt <= 24'h000000;
    end else if (st.activity && st.link == status_ctrl_pkg::LINK_CONNECTED) begin
      flash_cnt <= 24'(status_ctrl_pkg::FLASH_CYCLES);
    end else if (flash_cnt != 24'h000000) begin
      flash_cnt <= flash_cnt - 24'h000001;
    end
  end

  // ----------------------------------------
  // Colour selection
  // ----------------------------------------
  always_comb begin
    rgb = status_ctrl_pkg::LED_DARK;
    if (st.ready) begin
      unique case (st.link)
        status_ctrl_pkg::LINK_CONNECTING: rgb = status_ctrl_pkg::LED_PURPLE;
        status_ctrl_pkg::LINK_CONNECTED: begin
          rgb = (flash_cnt != 24'h000000) ? status_ctrl_pkg::LED_DARK : status_ctrl_pkg::LED_BLUE;
        end
        default: begin
          if (st.mode == status_ctrl_pkg::MODE_COMMAND) begin
            rgb = status_ctrl_pkg::LED_ORANGE;
          end else begin
            rgb = status_ctrl_pkg::LED_GREEN;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* src/status_ctrl_pkg.sv */
// Package with constants and types for the status LED and start-up switch control
`default_nettype none
package status_ctrl_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned FACTORY_HOLD_S = 10;
  localparam longint unsigned FACTORY_HOLD_CYCLES = longint'(FACTORY_HOLD_S) * longint'(CLK_HZ);
  localparam int unsigned FLASH_MS = 50;
  localparam int unsigned FLASH_CYCLES = FLASH_MS * (CLK_HZ / 1000);
  localparam int unsigned HOLD_W = 32;
  localparam int unsigned FLASH_W = 24;

  // ----------------------------------------
  // Modes and link states
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_DATA = 2'b00,
    MODE_EXT_FRAMED = 2'b01,
    MODE_COMMAND = 2'b10
  } sys_mode_e;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_CONNECTING = 2'b01,
    LINK_CONNECTED = 2'b10
  } link_state_e;

  // Start-up sequencer states
  typedef enum logic [2:0] {
    ST_SAMPLE = 3'b000,
    ST_BOOT_HOLD = 3'b001,
    ST_BOOT = 3'b010,
    ST_RUN = 3'b011
  } start_e;

  // Function selected for the data-set-ready input
  typedef enum logic [1:0] {
    DSR_CMD_MODE = 2'b00,
    DSR_DISCONNECT = 2'b01,
    DSR_UART_EN = 2'b10,
    DSR_SLEEP = 2'b11
  } dsr_fn_e;

  // What the data-terminal-ready output reports
  typedef enum logic [1:0] {
    DTR_MODE = 2'b00,
    DTR_PEERS = 2'b01,
    DTR_BONDED = 2'b10,
    DTR_PROFILE = 2'b11
  } dtr_fn_e;

  // LED drive levels {red, green, blue}, active low
  localparam logic [2:0] LED_DARK = 3'h7;
  localparam logic [2:0] LED_GREEN = 3'h5;
  localparam logic [2:0] LED_ORANGE = 3'h1;
  localparam logic [2:0] LED_PURPLE = 3'h2;
  localparam logic [2:0] LED_BLUE = 3'h6;
endpackage
`default_nettype wire

/* src/status_if.sv */
// Interface carrying mode and link status to the LED encoder
`default_nettype none
interface status_if;
  status_ctrl_pkg::sys_mode_e mode;
  status_ctrl_pkg::link_state_e link;
  logic ready;
  logic activity;
  modport src (output mode, output link, output ready, output activity);
  modport dst (input mode, input link, input ready, input activity);
endinterface
`default_nettype wire

/* src/status_led_and_startup_switch_ctrl.sv */
// Top of the status LED, start-up switch and modem-control logic
`default_nettype none
// Contract
// - Red, green and blue outputs are active low, a low level lights the element.
// - Idle shows green in data or extended framed mode and orange in command mode.
// - A connecting serial-emulation link shows purple and a connected one shows blue, in any mode.
// - While connected the blue indication flashes on each data activity.
// - Switch two low at start-up restores the serial settings to defaults.
// - In normal operation switch two requests a low-energy connection to a peripheral.
// - Both switches low at start-up enter the bootloader.
// - Both switches held low from start-up for 10 s leave the bootloader and restore factory defaults.
// - The reset input resets the whole system.
// - The data-set-ready input enters command mode, disconnects, gates the serial port or sleeps, by setting.
// - The data-terminal-ready output reports mode, peers, bonding or profile link, by setting.
module status_led_and_startup_switch_ctrl #(
  parameter longint unsigned HOLD_CYCLES = status_ctrl_pkg::FACTORY_HOLD_CYCLES
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic SWITCH_1_N,
  input wire logic SWITCH_2_N,
  input wire logic DSR_N,
  input wire logic [1:0] DSR_FUNC,
  input wire logic [1:0] DTR_FUNC,
  input wire logic EXT_FRAMED_SEL,
  input wire logic LINK_CONNECTING,
  input wire logic LINK_CONNECTED,
  input wire logic LINK_BONDED,
  input wire logic LINK_PROFILE,
  input wire logic DATA_ACTIVITY,
  input wire logic CMD_MODE_EXIT,
  output logic RED_N,
  output logic GREEN_N,
  output logic BLUE_N,
  output logic DTR_N,
  output logic SERIAL_DEFAULTS,
  output logic FACTORY_DEFAULTS,
  output logic BOOTLOADER,
  output logic CONNECT_REQ,
  output logic DISCONNECT_REQ,
  output logic CONNECTABLE,
  output logic UART_ENABLE,
  output logic SLEEP
);
  status_ctrl_pkg::start_e state;
  status_ctrl_pkg::sys_mode_e mode;
  status_ctrl_pkg::link_state_e link;
  logic [31:0] hold_cnt;
  logic [2:0] rgb;
  logic sw2_fall;
  logic dsr_fall;
  logic dsr_rise;
  logic running;
  logic both_pressed;
  logic hold_done;
  logic disc_evt;

  status_if st ();

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  // Both switches held low
  function automatic logic both_low(input logic s1_n, input logic s2_n);
    return !s1_n && !s2_n;
  endfunction

  // Selected data-set-ready function matches
  function automatic logic dsr_is(input logic [1:0] func, input status_ctrl_pkg::dsr_fn_e fn);
    return func == fn;
  endfunction

  // Mode held outside command mode
  function automatic status_ctrl_pkg::sys_mode_e idle_mode(input logic ext);
    if (ext) begin
      return status_ctrl_pkg::MODE_EXT_FRAMED;
    end
    return status_ctrl_pkg::MODE_DATA;
  endfunction

  assign running = (state == status_ctrl_pkg::ST_RUN);
  assign both_pressed = both_low(SWITCH_1_N, SWITCH_2_N);
  assign hold_done = 64'(hold_cnt) >= HOLD_CYCLES - 64'd1;
  assign disc_evt = running && dsr_is(DSR_FUNC, status_ctrl_pkg::DSR_DISCONNECT) && dsr_fall;

  // ----------------------------------------
  // Edge detectors
  // ----------------------------------------
  edge_detect u_sw2 (
    .clk(MCLK),
    .rst_n(RST_N),
    .din(SWITCH_2_N),
    .fall(sw2_fall),
    .rise()
  );

  edge_detect u_dsr (
    .clk(MCLK),
    .rst_n(RST_N),
    .din(DSR_N),
    .fall(dsr_fall),
    .rise(dsr_rise)
  );

  // ----------------------------------------
  // Start-up sequencer
  // ----------------------------------------
  // synchronous full reset
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state <= status_ctrl_pkg::ST_SAMPLE;
    end else begin
      unique case (state)
        status_ctrl_pkg::ST_SAMPLE: begin
          if (both_pressed) begin
            state <= status_ctrl_pkg::ST_BOOT_HOLD;
          end else begin
            state <= status_ctrl_pkg::ST_RUN;
          end
        end
        status_ctrl_pkg::ST_BOOT_HOLD: begin
          if (!both_pressed) begin
            state <= status_ctrl_pkg::ST_BOOT;
          end else if (hold_done) begin
            state <= status_ctrl_pkg::ST_RUN;
          end
        end
        // Early release parks in bootloader until reset
        status_ctrl_pkg::ST_BOOT: begin
          state <= status_ctrl_pkg::ST_BOOT;
        end
        status_ctrl_pkg::ST_RUN: begin
          state <= status_ctrl_pkg::ST_RUN;
        end
        default: begin
          state <= status_ctrl_pkg::ST_SAMPLE;
        end
      endcase
    end
  end

  // Counts only while in the boot-hold state
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      hold_cnt <= 32'h00000000;
    end else if (state == status_ctrl_pkg::ST_BOOT_HOLD) begin
      hold_cnt <= hold_cnt + 32'h00000001;
    end
  end

  // ----------------------------------------
  // Start-up results
  // ----------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      SERIAL_DEFAULTS <= 1'b0;
      FACTORY_DEFAULTS <= 1'b0;
      BOOTLOADER <= 1'b0;
    end else begin
      if (state == status_ctrl_pkg::ST_SAMPLE && !SWITCH_2_N) begin
        SERIAL_DEFAULTS <= 1'b1;
      end
      // Factory flag stays sticky until the next reset; bootloader flag clears when the hold completes
      if (state == status_ctrl_pkg::ST_SAMPLE) begin
        BOOTLOADER <= both_pressed;
      end else if (state == status_ctrl_pkg::ST_BOOT_HOLD && both_pressed && hold_done) begin
        BOOTLOADER <= 1'b0;
        FACTORY_DEFAULTS <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Connection request from switch two
  // ----------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      CONNECT_REQ <= 1'b0;
    end else begin
      CONNECT_REQ <= running && sw2_fall;
    end
  end

  // ----------------------------------------
  // Data-set-ready control
  // ----------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      mode <= status_ctrl_pkg::MODE_DATA;
    end else if (!running) begin
      mode <= status_ctrl_pkg::MODE_DATA;
    end else if (dsr_is(DSR_FUNC, status_ctrl_pkg::DSR_CMD_MODE) && dsr_fall) begin
      mode <= status_ctrl_pkg::MODE_COMMAND;
    end else if (mode == status_ctrl_pkg::MODE_COMMAND) begin
      if (CMD_MODE_EXIT) begin
        mode <= idle_mode(EXT_FRAMED_SEL);
      end
    end else begin
      mode <= idle_mode(EXT_FRAMED_SEL);
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      DISCONNECT_REQ <= 1'b0;
      CONNECTABLE <= 1'b1;
    end else begin
      DISCONNECT_REQ <= disc_evt;
      if (disc_evt) begin
        CONNECTABLE <= !CONNECTABLE;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      UART_ENABLE <= 1'b1;
      SLEEP <= 1'b0;
    end else begin
      UART_ENABLE <= !dsr_is(DSR_FUNC, status_ctrl_pkg::DSR_UART_EN) || !DSR_N;
      if (!dsr_is(DSR_FUNC, status_ctrl_pkg::DSR_SLEEP) || !running) begin
        SLEEP <= 1'b0;
      end else if (dsr_rise) begin
        SLEEP <= 1'b1;
      end else if (dsr_fall) begin
        SLEEP <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Link state and data-terminal-ready
  // ----------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      link <= status_ctrl_pkg::LINK_IDLE;
    end else if (LINK_CONNECTED) begin
      link <= status_ctrl_pkg::LINK_CONNECTED;
    end else if (LINK_CONNECTING) begin
      link <= status_ctrl_pkg::LINK_CONNECTING;
    end else begin
      link <= status_ctrl_pkg::LINK_IDLE;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      DTR_N <= 1'b1;
    end else begin
      // report selected status
      // Low reports the condition as true
      unique case (status_ctrl_pkg::dtr_fn_e'(DTR_FUNC))
        status_ctrl_pkg::DTR_MODE: begin
          DTR_N <= !(running && mode != status_ctrl_pkg::MODE_COMMAND);
        end
        status_ctrl_pkg::DTR_PEERS: begin
          DTR_N <= !(link == status_ctrl_pkg::LINK_CONNECTED);
        end
        status_ctrl_pkg::DTR_BONDED: begin
          DTR_N <= !LINK_BONDED;
        end
        status_ctrl_pkg::DTR_PROFILE: begin
          DTR_N <= !LINK_PROFILE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // LED drive
  // ----------------------------------------
  assign st.mode = mode;
  assign st.link = link;
  assign st.ready = running;
  assign st.activity = DATA_ACTIVITY;

  led_encoder u_led (
    .clk(MCLK),
    .rst_n(RST_N),
    .st(st),
    .rgb(rgb)
  );

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      RED_N <= 1'b1;
      GREEN_N <= 1'b1;
      BLUE_N <= 1'b1;
    end else begin
      RED_N <= rgb[2];
      GREEN_N <= rgb[1];
      BLUE_N <= rgb[0];
    end
  end
endmodule
`default_nettype wire
